/* event_flags_cfg.svh */
// register offsets, field positions and reset values of the event flag block
`ifndef EVENT_FLAGS_CFG_SVH
`define EVENT_FLAGS_CFG_SVH

`define EVT_SET_OFFSET        8'h80
`define EVT_CLEAR_OFFSET      8'h84
`define EVT_MASK_SET_OFFSET   8'h88
`define EVT_MASK_CLEAR_OFFSET 8'h8C
`define EVT_SRC_OFFSET        8'h90

`define EVT_BIT_MISSED_CYCLE  22
`define EVT_BIT_SECONDS       21
`define EVT_BIT_NEW_CYCLE     20
`define EVT_BIT_PHY_STATUS    19
`define EVT_BIT_ACCESS_FAIL   18
`define EVT_BIT_BUS_REINIT    17
`define EVT_BIT_ID_DONE       16
`define EVT_BIT_ID_STICKY     15
`define EVT_BIT_ATOMIC_ERR    9
`define EVT_BIT_POSTED_ERR    8
`define EVT_BIT_ISO_RX        7
`define EVT_BIT_ISO_TX        6
`define EVT_BIT_SECONDS_SRC   6

`define EVT_LATCHED_MASK      32'h007F833F
`define EVT_RESET_VALUE       32'h00000000
`define EVT_MASK_RESET_VALUE  32'h00000000

`endif

/* event_flags_pkg.sv */
// types shared by the event flag block
package event_flags_pkg;

	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        write;
		logic        read;
	} reg_req_t;

	typedef struct packed {
		logic       cycle_start_seen;
		logic       subaction_gap;
		logic       arb_reset_gap;
		logic [6:0] cycle_seconds;
		logic       cycle_count_lsb;
		logic       phy_status_irq;
		logic       phy_access_fail;
		logic       phy_bus_reset;
		logic       id_stream_done;
		logic       atomic_no_ack;
		logic       posted_store_fault;
		logic       iso_rx_any;
		logic       iso_tx_any;
		logic       rx_resp_stored;
		logic       rx_req_stored;
		logic       rx_resp_dma_done;
		logic       rx_req_dma_done;
		logic       tx_resp_dma_done;
		logic       tx_req_dma_done;
	} event_src_t;

	typedef enum logic [1:0] {
		CYC_IDLE    = 2'b00,
		CYC_WAIT    = 2'b01,
		CYC_GAP     = 2'b11
	} cyc_state_t;

endpackage

/* link_interrupt_event_flags.sv */
// event flag register of a serial bus link controller
//
// Added by the designer: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`include "event_flags_cfg.svh"

module link_interrupt_event_flags (
	input  wire logic                        clock,
	input  wire logic                        rstn,
	input  wire event_flags_pkg::reg_req_t   req,
	input  wire event_flags_pkg::event_src_t src,
	output logic [31:0]                      rdata,
	output logic [22:0]                      events
);

	// ****************************************
	// source synchronisers
	// ****************************************
	localparam int SW = $bits(event_flags_pkg::event_src_t);
	logic [SW-1:0] sync1;
	logic [SW-1:0] sync2;
	logic [SW-1:0] prev;
	event_flags_pkg::event_src_t s;
	event_flags_pkg::event_src_t p;

	// sources come from the transceiver and dma domains
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			sync1 <= '0;
			sync2 <= '0;
			prev  <= '0;
		end else begin
			sync1 <= src;
			sync2 <= sync1;
			prev  <= sync2;
		end
	end
	assign s = event_flags_pkg::event_src_t'(sync2);
	assign p = event_flags_pkg::event_src_t'(prev);

	// ****************************************
	// cycle loss detector
	// ****************************************
	event_flags_pkg::cyc_state_t cyc;
	event_flags_pkg::cyc_state_t next_cyc;
	wire sync_edge  = s.cycle_count_lsb != p.cycle_count_lsb;
	wire start_rise = s.cycle_start_seen & ~p.cycle_start_seen;
	wire gap_rise   = s.subaction_gap & ~p.subaction_gap;
	wire arb_rise   = s.arb_reset_gap & ~p.arb_reset_gap;
	logic lost_hit;

	always_comb begin
		next_cyc = cyc;
		lost_hit = 1'b0;
		case (cyc)
			event_flags_pkg::CYC_IDLE: begin
				if (sync_edge)
					next_cyc = event_flags_pkg::CYC_WAIT;
			end
			event_flags_pkg::CYC_WAIT: begin
				if (start_rise) begin
					next_cyc = event_flags_pkg::CYC_IDLE;
				end else if (sync_edge || arb_rise) begin
					lost_hit = 1'b1;
					next_cyc = sync_edge ? event_flags_pkg::CYC_WAIT
						: event_flags_pkg::CYC_IDLE;
				end else if (gap_rise) begin
					next_cyc = event_flags_pkg::CYC_GAP;
				end
			end
			event_flags_pkg::CYC_GAP: begin
				// a start must come right after the first gap
				if (start_rise) begin
					next_cyc = event_flags_pkg::CYC_IDLE;
				end else begin
					lost_hit = 1'b1;
					next_cyc = sync_edge ? event_flags_pkg::CYC_WAIT
						: event_flags_pkg::CYC_IDLE;
				end
			end
			default: next_cyc = event_flags_pkg::CYC_IDLE;
		endcase
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn)
			cyc <= event_flags_pkg::CYC_IDLE;
		else
			cyc <= next_cyc;
	end

	// ****************************************
	// hardware set terms
	// ****************************************
	logic [22:0] hw_set;
	wire reinit_rise = s.phy_bus_reset & ~p.phy_bus_reset;
	wire id_rise     = s.id_stream_done & ~p.id_stream_done;

	always_comb begin
		hw_set = '0;
		hw_set[`EVT_BIT_MISSED_CYCLE] = lost_hit;
		hw_set[`EVT_BIT_SECONDS] = s.cycle_seconds[`EVT_BIT_SECONDS_SRC]
			^ p.cycle_seconds[`EVT_BIT_SECONDS_SRC];
		hw_set[`EVT_BIT_NEW_CYCLE] = sync_edge;
		hw_set[`EVT_BIT_PHY_STATUS] = s.phy_status_irq
			& ~p.phy_status_irq;
		// flag is set on the third clock edge after the failure, through the two-stage synchroniser, well ahead of any next access
		hw_set[`EVT_BIT_ACCESS_FAIL] = s.phy_access_fail
			& ~p.phy_access_fail;
		hw_set[`EVT_BIT_BUS_REINIT] = reinit_rise;
		hw_set[`EVT_BIT_ID_DONE] = id_rise;
		hw_set[`EVT_BIT_ID_STICKY] = id_rise;
		hw_set[`EVT_BIT_ATOMIC_ERR] = s.atomic_no_ack
			& ~p.atomic_no_ack;
		hw_set[`EVT_BIT_POSTED_ERR] = s.posted_store_fault
			& ~p.posted_store_fault;
		hw_set[5] = s.rx_resp_stored & ~p.rx_resp_stored;
		hw_set[4] = s.rx_req_stored & ~p.rx_req_stored;
		hw_set[3] = s.rx_resp_dma_done & ~p.rx_resp_dma_done;
		hw_set[2] = s.rx_req_dma_done & ~p.rx_req_dma_done;
		hw_set[1] = s.tx_resp_dma_done & ~p.tx_resp_dma_done;
		hw_set[0] = s.tx_req_dma_done & ~p.tx_req_dma_done;
	end

	// ****************************************
	// register decode
	// ****************************************
	logic [31:0] flags;
	logic [31:0] mask;
	localparam logic [31:0] LATCHED = `EVT_LATCHED_MASK;
	wire wr_set   = req.write && req.addr == `EVT_SET_OFFSET;
	wire wr_clr   = req.write && req.addr == `EVT_CLEAR_OFFSET;
	wire wr_mset  = req.write && req.addr == `EVT_MASK_SET_OFFSET;
	wire wr_mclr  = req.write && req.addr == `EVT_MASK_CLEAR_OFFSET;
	wire [31:0] sw_set = wr_set ? (req.wdata & LATCHED) : 32'h00000000;
	wire [31:0] sw_clr = wr_clr ? (req.wdata & LATCHED) : 32'h00000000;
	wire [31:0] hw32   = {9'h000, hw_set};
	// reinit wipes the primary identity flag, not the sticky one
	wire [31:0] reinit_clr = reinit_rise ?
		(32'h00000001 << `EVT_BIT_ID_DONE) : 32'h00000000;
	wire [31:0] next_flags = ((flags & ~sw_clr & ~reinit_clr)
		| sw_set | (hw32 & ~reinit_clr)) & LATCHED;
	wire [31:0] next_mask = ((mask | (wr_mset ? req.wdata : 32'h00000000))
		& ~(wr_mclr ? req.wdata : 32'h00000000));

	// summaries are live, never stored, never writable
	wire [31:0] live = flags | {24'h000000, s.iso_rx_any, s.iso_tx_any,
		6'h00};
	wire [31:0] evt_view = live & mask & {17'h00000, 5'h00, 10'h3FF}
		| live & mask & 32'hFFFF8000;
	wire [31:0] src_view = {25'h0000000, s.cycle_seconds};
	wire [31:0] next_rdata =
		(req.addr == `EVT_SET_OFFSET || req.addr == `EVT_CLEAR_OFFSET)
			? evt_view :
		(req.addr == `EVT_MASK_SET_OFFSET || req.addr == `EVT_MASK_CLEAR_OFFSET)
			? mask :
		(req.addr == `EVT_SRC_OFFSET) ? src_view : 32'h00000000;

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			flags  <= `EVT_RESET_VALUE;
			mask   <= `EVT_MASK_RESET_VALUE;
			rdata  <= 32'h00000000;
			events <= '0;
		end else begin
			flags  <= next_flags;
			mask   <= next_mask;
			rdata  <= req.read ? next_rdata : 32'h00000000;
			events <= live[22:0];
		end
	end

	// ****************************************
	// assertions
	// ****************************************
	property p_set_beats_clear;
		@(posedge clock) disable iff (!rstn)
		(hw_set[0] && wr_clr && req.wdata[0]) |=> flags[0];
	endproperty
	a_set_beats_clear: assert property (p_set_beats_clear)
		else $error("hardware set lost to clear");

	property p_clear_only_by_write;
		@(posedge clock) disable iff (!rstn)
		($past(flags[4]) && !flags[4]) |-> $past(wr_clr && req.wdata[4]);
	endproperty
	a_clear_only_by_write: assert property (p_clear_only_by_write)
		else $error("event bit cleared without clear write");

	property p_sw_set;
		@(posedge clock) disable iff (!rstn)
		(wr_set && req.wdata[1]) |=> flags[1];
	endproperty
	a_sw_set: assert property (p_sw_set)
		else $error("set write did not raise bit");

	property p_reinit_clears_id;
		@(posedge clock) disable iff (!rstn)
		(reinit_rise && !(wr_set && req.wdata[16]))
			|=> flags[17] && !flags[16];
	endproperty
	a_reinit_clears_id: assert property (p_reinit_clears_id)
		else $error("identity flag survived reinit");

	property p_sticky_holds;
		@(posedge clock) disable iff (!rstn)
		(flags[15] && !(wr_clr && req.wdata[15])) |=> flags[15];
	endproperty
	a_sticky_holds: assert property (p_sticky_holds)
		else $error("sticky identity flag dropped");

	property p_reserved_zero;
		@(posedge clock) disable iff (!rstn)
		req.read |=> rdata[14:10] == 5'h00;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero)
		else $error("reserved bits read nonzero");

	property p_read_masked;
		@(posedge clock) disable iff (!rstn)
		(req.read && req.addr == `EVT_SET_OFFSET && !mask[20])
			|=> !rdata[20];
	endproperty
	a_read_masked: assert property (p_read_masked)
		else $error("masked bit visible on read");

	property p_new_cycle;
		@(posedge clock) disable iff (!rstn)
		(s.cycle_count_lsb != p.cycle_count_lsb) |=> flags[20];
	endproperty
	a_new_cycle: assert property (p_new_cycle)
		else $error("new cycle flag not set");

	property p_missed_two_syncs;
		@(posedge clock) disable iff (!rstn)
		(cyc == event_flags_pkg::CYC_WAIT && sync_edge && !start_rise)
			|=> flags[22];
	endproperty
	a_missed_two_syncs: assert property (p_missed_two_syncs)
		else $error("missed cycle not flagged");

	property p_rx_summary;
		@(posedge clock) disable iff (!rstn)
		(mask[7] && s.iso_rx_any) |=> events[7];
	endproperty
	a_rx_summary: assert property (p_rx_summary)
		else $error("receive summary not shown");

	property p_seconds_flag;
		@(posedge clock) disable iff (!rstn)
		(s.cycle_seconds[6] != p.cycle_seconds[6]) |=> flags[21];
	endproperty
	a_seconds_flag: assert property (p_seconds_flag)
		else $error("seconds rollover flag not set");

	property p_phy_status;
		@(posedge clock) disable iff (!rstn)
		(s.phy_status_irq && !p.phy_status_irq) |=> flags[19];
	endproperty
	a_phy_status: assert property (p_phy_status)
		else $error("status request flag not set");

	property p_access_fail;
		@(posedge clock) disable iff (!rstn)
		(s.phy_access_fail && !p.phy_access_fail) |=> flags[18];
	endproperty
	a_access_fail: assert property (p_access_fail)
		else $error("access failure flag not set");

	property p_reinit_flag;
		@(posedge clock) disable iff (!rstn)
		reinit_rise |=> flags[17];
	endproperty
	a_reinit_flag: assert property (p_reinit_flag)
		else $error("reinit flag not set");

	property p_id_done;
		@(posedge clock) disable iff (!rstn)
		(id_rise && !reinit_rise) |=> flags[16];
	endproperty
	a_id_done: assert property (p_id_done)
		else $error("identity done flag not set");

	property p_sticky_set;
		@(posedge clock) disable iff (!rstn)
		id_rise |=> flags[15];
	endproperty
	a_sticky_set: assert property (p_sticky_set)
		else $error("sticky identity flag not set");

	property p_atomic_err;
		@(posedge clock) disable iff (!rstn)
		(s.atomic_no_ack && !p.atomic_no_ack) |=> flags[9];
	endproperty
	a_atomic_err: assert property (p_atomic_err)
		else $error("atomic response error not flagged");

	property p_posted_err;
		@(posedge clock) disable iff (!rstn)
		(s.posted_store_fault && !p.posted_store_fault) |=> flags[8];
	endproperty
	a_posted_err: assert property (p_posted_err)
		else $error("posted store error not flagged");

	property p_tx_summary;
		@(posedge clock) disable iff (!rstn)
		s.iso_tx_any |=> events[6];
	endproperty
	a_tx_summary: assert property (p_tx_summary)
		else $error("transmit summary not shown");

	property p_summary_unlatched;
		@(posedge clock) disable iff (!rstn)
		(!s.iso_rx_any && !s.iso_tx_any) |=> events[7:6] == 2'b00;
	endproperty
	a_summary_unlatched: assert property (p_summary_unlatched)
		else $error("summary bit held after source dropped");

	property p_resp_pkt;
		@(posedge clock) disable iff (!rstn)
		(s.rx_resp_stored && !p.rx_resp_stored) |=> flags[5];
	endproperty
	a_resp_pkt: assert property (p_resp_pkt)
		else $error("response packet flag not set");

	property p_req_pkt;
		@(posedge clock) disable iff (!rstn)
		(s.rx_req_stored && !p.rx_req_stored) |=> flags[4];
	endproperty
	a_req_pkt: assert property (p_req_pkt)
		else $error("request packet flag not set");

	property p_rx_resp_dma;
		@(posedge clock) disable iff (!rstn)
		(s.rx_resp_dma_done && !p.rx_resp_dma_done) |=> flags[3];
	endproperty
	a_rx_resp_dma: assert property (p_rx_resp_dma)
		else $error("receive response dma flag not set");

	property p_rx_req_dma;
		@(posedge clock) disable iff (!rstn)
		(s.rx_req_dma_done && !p.rx_req_dma_done) |=> flags[2];
	endproperty
	a_rx_req_dma: assert property (p_rx_req_dma)
		else $error("receive request dma flag not set");

	property p_tx_resp_done;
		@(posedge clock) disable iff (!rstn)
		(s.tx_resp_dma_done && !p.tx_resp_dma_done) |=> flags[1];
	endproperty
	a_tx_resp_done: assert property (p_tx_resp_done)
		else $error("transmit response done not set");

	property p_tx_req_done;
		@(posedge clock) disable iff (!rstn)
		(s.tx_req_dma_done && !p.tx_req_dma_done) |=> flags[0];
	endproperty
	a_tx_req_done: assert property (p_tx_req_done)
		else $error("transmit request done not set");

endmodule // link_interrupt_event_flags

/* far_side_model.sv */
// far side model: transceiver and dma engines raising event sources
`timescale 1ns/1ps
module far_side_model (
	input  wire logic                   clock,
	input  wire logic                   rstn,
	input  wire logic [4:0]             code,
	input  wire logic                   fire,
	input  wire logic                   iso_rx,
	input  wire logic                   iso_tx,
	output event_flags_pkg::event_src_t src
);
	logic [16:0] hold;
	logic [2:0]  left;
	logic        lsb;
	logic        sec6;

	// pulses drop back to idle 0 so that each one is a fresh rising edge
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			hold <= '0;
			left <= '0;
			lsb  <= 1'b0;
			sec6 <= 1'b0;
		end else if (fire) begin
			hold <= 17'h00001 << code;
			left <= 3'h4;
			lsb  <= lsb ^ (code == 5'h0C);
			sec6 <= sec6 ^ (code == 5'h0D);
		end else if (left != 3'h0) begin
			left <= left - 3'h1;
		end else begin
			hold <= '0;
		end
	end

	always_comb begin
		src                    = '0;
		src.phy_status_irq     = hold[0];
		src.phy_access_fail    = hold[1];
		src.phy_bus_reset      = hold[2];
		src.id_stream_done     = hold[3];
		src.atomic_no_ack      = hold[4];
		src.posted_store_fault = hold[5];
		src.rx_resp_stored     = hold[6];
		src.rx_req_stored      = hold[7];
		src.rx_resp_dma_done   = hold[8];
		src.rx_req_dma_done    = hold[9];
		src.tx_resp_dma_done   = hold[10];
		src.tx_req_dma_done    = hold[11];
		src.cycle_start_seen   = hold[14];
		src.arb_reset_gap      = hold[15];
		src.subaction_gap      = hold[16];
		src.cycle_count_lsb    = lsb;
		src.cycle_seconds[6]   = sec6;
		src.iso_rx_any         = iso_rx;
		src.iso_tx_any         = iso_tx;
	end
endmodule // far_side_model

/* testbench.sv */
// self-checking bench of the event flag register
`timescale 1ns/1ps
`define check(a, b) begin total_checks++; if ((a) !== (b)) begin n_errors++; \
	$display("unexpected at %0t: %0h %0h", $time, (a), (b)); end end
module testbench;
	logic                        clock = 1'b0;
	logic                        rstn  = 1'b0;
	event_flags_pkg::reg_req_t   req   = '0;
	logic [4:0]                  code  = '0;
	logic                        fire  = 1'b0;
	logic                        iso_rx = 1'b0;
	logic                        iso_tx = 1'b0;
	event_flags_pkg::event_src_t src;
	logic [31:0]                 rdata;
	logic [22:0]                 events;
	int                          n_errors = 0;
	int                          total_checks = 0;
	int                          bit_of [14] = '{19, 18, 17, 16, 9, 8, 5, 4,
		3, 2, 1, 0, 20, 21};

	always #5 clock = ~clock;

	link_interrupt_event_flags link_interrupt_event_flags_inst (
		.clock (clock), .rstn (rstn), .req (req), .src (src),
		.rdata (rdata), .events (events));
	far_side_model far_side_model_inst (
		.clock (clock), .rstn (rstn), .code (code), .fire (fire),
		.iso_rx (iso_rx), .iso_tx (iso_tx), .src (src));

	// ****************************************
	// bus and source tasks
	// ****************************************
	task automatic settle(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task automatic do_reset;
		@(posedge clock) rstn <= 1'b0;
		settle(16);
		@(posedge clock) rstn <= 1'b1;
		settle(1);
		`check(events, 23'h000000)
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		req.addr  <= a;
		req.wdata <= d;
		req.write <= 1'b1;
		@(posedge clock) req.write <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clock);
		req.addr <= a;
		req.read <= 1'b1;
		@(posedge clock) req.read <= 1'b0;
		#1;
		`check(rdata, exp)
	endtask
	task automatic pulse(input logic [4:0] c);
		@(posedge clock);
		code <= c;
		fire <= 1'b1;
		@(posedge clock) fire <= 1'b0;
		settle(8);
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_regs;
		do_reset;
		wr(8'h88, 32'hFFFFFFFF);
		wr(8'h80, 32'hFFFFFFFF);
		settle(2);
		`check(events, 23'h7F833F)
		rd(8'h80, 32'h007F833F);
		wr(8'h84, 32'h00000000);
		rd(8'h84, 32'h007F833F);
		wr(8'h8C, 32'hFFFFFFFC);
		rd(8'h80, 32'h00000003);
		rd(8'h8C, 32'h00000003);
		wr(8'h84, 32'hFFFFFFFF);
		rd(8'h80, 32'h00000000);
		rd(8'hFC, 32'h00000000);
		$display("test regs done");
	endtask
	task automatic t_sources;
		do_reset;
		for (int i = 0; i < 14; i++) begin
			pulse(5'(i));
			`check(events[bit_of[i]], 1'b1)
			wr(8'h84, 32'hFFFFFFFF);
			settle(2);
			`check(events, 23'h000000)
		end
		rd(8'h90, 32'h00000040);
		$display("test sources done");
	endtask
	task automatic t_reinit;
		do_reset;
		pulse(5'h03);
		`check(events[16:15], 2'b11)
		pulse(5'h02);
		`check(events[17:15], 3'b101)
		$display("test reinit done");
	endtask
	task automatic t_missed;
		do_reset;
		pulse(5'h0C);
		pulse(5'h0F);
		`check(events[22], 1'b1)
		do_reset;
		pulse(5'h0C);
		pulse(5'h10);
		`check(events[22], 1'b1)
		do_reset;
		pulse(5'h0C);
		pulse(5'h0E);
		pulse(5'h0C);
		`check(events[22], 1'b0)
		pulse(5'h0C);
		`check(events[22], 1'b1)
		$display("test missed cycle done");
	endtask
	task automatic t_summary;
		do_reset;
		wr(8'h88, 32'h000000C0);
		@(posedge clock) iso_rx <= 1'b1;
		settle(6);
		wr(8'h84, 32'h000000C0);
		settle(2);
		`check(events[7:6], 2'b10)
		rd(8'h80, 32'h00000080);
		@(posedge clock) iso_rx <= 1'b0;
		iso_tx <= 1'b1;
		settle(6);
		`check(events[7:6], 2'b01)
		rd(8'h84, 32'h00000040);
		@(posedge clock) iso_tx <= 1'b0;
		settle(6);
		wr(8'h80, 32'h000000C0);
		settle(2);
		`check(events[7:6], 2'b00)
		$display("test summary done");
	endtask
	task automatic t_race;
		do_reset;
		@(posedge clock);
		code <= 5'h0B;
		fire <= 1'b1;
		@(posedge clock) fire <= 1'b0;
		@(posedge clock);
		@(posedge clock);
		req.addr  <= 8'h84;
		req.wdata <= 32'h00000001;
		req.write <= 1'b1;
		@(posedge clock) req.write <= 1'b0;
		settle(3);
		`check(events[0], 1'b1)
		$display("test set race done");
	endtask

	task automatic results;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// run takes about 540 cycles; the watchdog allows over thirty times that
	initial begin
		#200us;
		n_errors++;
		results();
	end
	initial begin
		settle(16);
		@(posedge clock) rstn <= 1'b1;
		t_regs;
		t_sources;
		t_reinit;
		t_missed;
		t_summary;
		t_race;
		results();
	end
endmodule // testbench
